// ### adc_proc_pkg.sv
// shared constants, register map and stream types for the converter 9-12 post-processing block
`default_nettype none
package adc_proc_pkg;
  // ****************************************
  // register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [5:0] IDX_GLOBAL = 6'h03;
  localparam logic [5:0] IDX_PATSEL = 6'h04;
  localparam logic [5:0] IDX_C11_ODD = 6'h29;
  localparam logic [5:0] IDX_C11_EVEN = 6'h2A;
  localparam logic [5:0] IDX_C12_ODD = 6'h2B;
  localparam logic [5:0] IDX_C12_EVEN = 6'h2C;
  localparam logic [5:0] IDX_PAT_HPF = 6'h2D;
  localparam logic [5:0] IDX_STATUS = 6'h3E;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int GAIN_EN_BIT = 12;
  localparam int OFFSET_EN_BIT = 8;
  localparam int PATSEL_BIT = 8;
  localparam int GAIN_MSB = 15;
  localparam int GAIN_LSB = 11;
  localparam int OFFSET_MSB = 9;
  localparam int OFFSET_LSB = 0;
  localparam int PRBS_LANE9_BIT = 15;
  localparam int PAT9_LSB = 9;
  localparam int PAT10_LSB = 6;
  localparam int PAT_W = 3;
  localparam int ROUND_BIT = 5;
  localparam int CORNER_LSB = 1;
  localparam int CORNER_W = 4;
  localparam int HPF_EN_BIT = 0;
  localparam int STATUS_LEVEL_LSB = 0;
  localparam int STATUS_FULL_BIT = 8;
  localparam int STATUS_VALID_BIT = 9;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ****************************************
  // datapath sizes and constants
  // ****************************************
  localparam int FIFO_DEPTH = 32;
  localparam int LEVEL_W = $clog2(FIFO_DEPTH) + 1;
  localparam int GAIN_FRAC = 14;
  localparam int HPF_FRAC = 10;
  localparam logic signed [25:0] ROUND_HALF = 26'sh000_0200;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  // gain in steps of 0.2 dB, unsigned with 14 fraction bits
  localparam logic [15:0] GAIN_TABLE [32] = '{
    16'h4000, 16'h417E, 16'h4304, 16'h4494, 16'h462D, 16'h47CF, 16'h497B, 16'h4B32,
    16'h4CF2, 16'h4EBD, 16'h5092, 16'h5273, 16'h545F, 16'h5656, 16'h5858, 16'h5A67,
    16'h5C82, 16'h5EAA, 16'h60DE, 16'h6320, 16'h656F, 16'h67CC, 16'h6A37, 16'h6CB0,
    16'h6F38, 16'h71CF, 16'h7476, 16'h772D, 16'h79F3, 16'h7CCB, 16'h7FB3, 16'h82AC};
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] conv; // 0..3 = converters 9..12
    logic odd;
    logic signed [13:0] data;
  } sample_type;
  typedef struct packed {
    logic [1:0] lane; // 0..3 = outputs 9..12
    logic prbs;
    logic [2:0] pattern;
    logic [13:0] data;
  } lane_word_type;
  typedef struct packed {
    logic [4:0] gain;
    logic [9:0] offset;
  } gain_offset_type;
  typedef struct packed {
    logic gainEn;
    logic offsetEn;
    logic hpfEn;
    logic roundEn;
    logic [3:0] corner;
    gain_offset_type [3:0] go; // index {converter 12, odd}
  } proc_cfg_type;
endpackage
`default_nettype wire

// ### sample_fifo.sv
// word fifo with registered read data, standing between processing and the lanes
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic wrValid, // write request
  output logic wrReady, // room left
  input wire logic [WIDTH-1:0] wrData, // write word
  output logic rdValid, // read word present
  input wire logic rdReady, // reader takes word
  output logic [WIDTH-1:0] rdData, // read word, registered
  output logic [$clog2(DEPTH):0] level // words in storage
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // handshakes; output stage refills as soon as it empties
  assign wrReady = count != FULL;
  assign push = wrValid && wrReady;
  assign pop = (count != '0) && (!rdValid || rdReady);
  assign level = count;

  // storage and pointers
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr] <= wrData;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // registered read port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdValid <= 1'b0;
      rdData <= '0;
    end else if (pop) begin
      rdValid <= 1'b1;
      rdData <= mem[rdPtr];
    end else if (rdReady) begin
      rdValid <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_fifo_full_stop:
    assert property (count == FULL - 1'b1 && push && !pop |=> !wrReady && count == FULL)
      else $error("fifo did not report full");
endmodule // sample_fifo
`default_nettype wire

// ### sample_proc.sv
// offset, gain and high-pass stage for one sample stream of converters 9 to 12
`timescale 1ns/1ps
`default_nettype none
module sample_proc (
  input wire logic sys_clk, // system clock
  input wire logic reset, // sync reset, high
  input wire adc_proc_pkg::proc_cfg_type cfg, // settings from registers
  input wire logic inValid, // sample offered
  output logic inReady, // sample taken
  input wire adc_proc_pkg::sample_type inSample, // raw sample
  output logic outValid, // processed sample present
  input wire logic outReady, // downstream takes it
  output var adc_proc_pkg::sample_type outSample // processed sample, registered
);
  logic inFire;
  logic apply;
  adc_proc_pkg::gain_offset_type sel;
  logic [15:0] gSel;
  logic signed [9:0] offs;
  logic signed [15:0] diff;
  logic signed [31:0] prod;
  logic signed [13:0] scaled;
  logic signed [23:0] acc [4];
  logic signed [23:0] accSel;
  logic signed [24:0] err;
  logic signed [13:0] truncOut;
  logic signed [13:0] roundOut;
  logic signed [13:0] result;

  function automatic logic signed [13:0] sat14(input logic signed [25:0] v);
    if (v > 26'sh1FFF) return 14'sh1FFF;
    if (v < 26'sh3FF_E000) return 14'sh2000;
    return v[13:0];
  endfunction

  // ****************************************
  // offset and gain
  // ****************************************
  assign inReady = !outValid || outReady;
  assign inFire = inValid && inReady;
  // only converters 11 and 12 are trimmed here
  assign apply = inSample.conv[1];
  assign sel = cfg.go[{inSample.conv[0], inSample.odd}];
  assign offs = (cfg.offsetEn && apply) ? $signed(sel.offset) : '0;
  assign gSel = (cfg.gainEn && apply) ? adc_proc_pkg::GAIN_TABLE[sel.gain]
                                      : adc_proc_pkg::GAIN_UNITY;
  // offset is in 14-bit steps, so it subtracts straight from the sample
  assign diff = 16'(inSample.data) - 16'(offs);
  assign prod = 32'(diff) * $signed({16'h0000, gSel});
  assign scaled = sat14(26'(prod >>> adc_proc_pkg::GAIN_FRAC));

  // ****************************************
  // high-pass: subtract a tracked dc estimate per converter
  // ****************************************
  assign accSel = acc[inSample.conv];
  assign err = (25'(scaled) <<< adc_proc_pkg::HPF_FRAC) - 25'(accSel);
  assign truncOut = sat14(26'(err >>> adc_proc_pkg::HPF_FRAC));
  assign roundOut = sat14((26'(err) + adc_proc_pkg::ROUND_HALF) >>> adc_proc_pkg::HPF_FRAC);
  // filter off means a plain bypass
  assign result = !cfg.hpfEn ? scaled : (cfg.roundEn ? roundOut : truncOut);

  // estimate moves by 2^-k of the error; held while the filter is off
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) acc[i] <= '0;
    end else if (inFire && cfg.hpfEn) begin
      acc[inSample.conv] <= accSel + 24'(err >>> cfg.corner);
    end
  end

  // output register; holds while downstream stalls
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      outValid <= 1'b0;
      outSample <= '0;
    end else begin
      if (inReady) outValid <= inValid;
      if (inFire) outSample <= {inSample.conv, inSample.odd, result};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_gain_gated:
    assert property (!(cfg.gainEn && apply) |-> gSel == adc_proc_pkg::GAIN_UNITY)
      else $error("gain applied while disabled");
  a_gain_zero_unity:
    assert property (inFire && cfg.gainEn && apply && !cfg.offsetEn && !cfg.hpfEn
                     && sel.gain == 5'h00 |=> outSample.data == $past(inSample.data))
      else $error("zero gain code changed the sample");
  a_offset_subtract:
    assert property (inFire && !cfg.gainEn && cfg.offsetEn && apply && !cfg.hpfEn
                     |=> outSample.data == $past(sat14(26'(inSample.data)
                                                 - 26'($signed(sel.offset)))))
      else $error("offset not subtracted");
  a_offset_gated:
    assert property (inFire && !cfg.offsetEn && !cfg.gainEn && !cfg.hpfEn
                     |=> outSample.data == $past(inSample.data))
      else $error("sample changed with trims off");
  a_hpf_truncate:
    assert property (inFire && cfg.hpfEn && !cfg.roundEn |=> outSample.data == $past(truncOut))
      else $error("filter output not truncated");
  a_hpf_bypass:
    assert property (inFire && !cfg.hpfEn |=> outSample.data == $past(scaled) && outValid)
      else $error("filter not bypassed");
endmodule // sample_proc
`default_nettype wire

// ### adc9_12_digital_proc_config.sv
// configuration registers and sample path for converters 9 to 12 and lanes 9 to 12
//
// Notes on behaviour
// - gain field value N gives N times 0.2 dB digital gain.
// - gain fields act only while the global gain enable is set.
// - offset field is two's complement, 14-bit steps, subtracted from sample.
// - offset fields act only while the global offset enable is set.
// - odd and even samples each use their own gain and offset.
// - prbs bits 15..12 pick prbs on lanes 9..12 under per-lane select.
// - pattern fields for lanes 9 and 10 act only under per-lane select.
// - high-pass output truncated when bit 5 clear, rounded when set.
// - bits 4..1 hold the corner k, 2 to 10, used when filter enabled.
// - bit 0 enables the high-pass filter; clear bypasses it.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adc9_12_digital_proc_config (
  input wire logic sys_clk, // 20 MHz system clock
  input wire logic reset, // sync reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error
  input wire logic sampleValid, // raw sample offered
  output logic sampleReady, // raw sample taken
  input wire adc_proc_pkg::sample_type sample, // raw sample
  output logic laneValid, // lane word present
  input wire logic laneReady, // serializer takes word
  output var adc_proc_pkg::lane_word_type laneWord // lane word, registered
);
  // ****************************************
  // declarations
  // ****************************************
  logic [15:0] goWord [4];
  logic [15:0] patCtrl;
  logic globalGainEnable;
  logic globalOffsetEnable;
  logic perLanePatternSelect;
  logic [5:0] regIdx;
  logic goHit;
  logic [1:0] goIdx;
  logic mapped;
  logic [15:0] rdValue;
  logic setupPhase;
  logic wrEn;
  adc_proc_pkg::proc_cfg_type cfg;
  logic procValid;
  adc_proc_pkg::sample_type procOut;
  logic fifoReady;
  adc_proc_pkg::lane_word_type fifoIn;
  logic push;
  logic prbsOn;
  logic [14:0] prbsState;
  logic [adc_proc_pkg::LEVEL_W-1:0] fifoLevel;
  logic [2:0] lane9Pattern;
  logic [2:0] lane10Pattern;

  // keeps unwritten byte lanes
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // apb decode
  // ****************************************
  assign regIdx = paddr[7:2];
  assign pready = 1'b1; // zero wait states
  assign setupPhase = psel && !penable;
  // error is latched in setup, so a refused write never lands
  assign wrEn = psel && penable && pwrite && !pslverr;

  // gain and offset words, indexed {converter 12, odd}
  always_comb begin
    goHit = 1'b1;
    goIdx = 2'h0;
    case (regIdx)
      adc_proc_pkg::IDX_C11_ODD: goIdx = 2'h1;
      adc_proc_pkg::IDX_C11_EVEN: goIdx = 2'h0;
      adc_proc_pkg::IDX_C12_ODD: goIdx = 2'h3;
      adc_proc_pkg::IDX_C12_EVEN: goIdx = 2'h2;
      default: goHit = 1'b0;
    endcase
  end

  // read mux; bits not held read as zero
  always_comb begin
    rdValue = '0;
    mapped = 1'b1;
    if (goHit) begin
      rdValue = goWord[goIdx];
    end else begin
      case (regIdx)
        adc_proc_pkg::IDX_GLOBAL: begin
          rdValue[adc_proc_pkg::GAIN_EN_BIT] = globalGainEnable;
          rdValue[adc_proc_pkg::OFFSET_EN_BIT] = globalOffsetEnable;
        end
        adc_proc_pkg::IDX_PATSEL: rdValue[adc_proc_pkg::PATSEL_BIT] = perLanePatternSelect;
        adc_proc_pkg::IDX_PAT_HPF: rdValue = patCtrl;
        adc_proc_pkg::IDX_STATUS: begin
          rdValue[adc_proc_pkg::STATUS_LEVEL_LSB +: adc_proc_pkg::LEVEL_W] = fifoLevel;
          rdValue[adc_proc_pkg::STATUS_FULL_BIT] = !fifoReady;
          rdValue[adc_proc_pkg::STATUS_VALID_BIT] = laneValid;
        end
        default: mapped = 1'b0;
      endcase
    end
  end

  // answer captured in setup, presented through the access phase
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= {16'h0000, rdValue};
      pslverr <= !mapped || (pwrite && regIdx == adc_proc_pkg::IDX_STATUS);
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // gain and offset words
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) goWord[i] <= adc_proc_pkg::REG_RESET;
    end else if (wrEn && goHit) begin
      goWord[goIdx] <= merge(goWord[goIdx], pwdata, pstrb);
    end
  end

  // pattern and filter word
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      patCtrl <= adc_proc_pkg::REG_RESET;
    end else if (wrEn && regIdx == adc_proc_pkg::IDX_PAT_HPF) begin
      patCtrl <= merge(patCtrl, pwdata, pstrb);
    end
  end

  // global enables; each sits in byte lane 1
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      globalGainEnable <= 1'b0;
      globalOffsetEnable <= 1'b0;
      perLanePatternSelect <= 1'b0;
    end else if (wrEn) begin
      if (regIdx == adc_proc_pkg::IDX_GLOBAL && pstrb[adc_proc_pkg::GAIN_EN_BIT / 8]) begin
        globalGainEnable <= pwdata[adc_proc_pkg::GAIN_EN_BIT];
        globalOffsetEnable <= pwdata[adc_proc_pkg::OFFSET_EN_BIT];
      end
      if (regIdx == adc_proc_pkg::IDX_PATSEL && pstrb[adc_proc_pkg::PATSEL_BIT / 8]) begin
        perLanePatternSelect <= pwdata[adc_proc_pkg::PATSEL_BIT];
      end
    end
  end

  // ****************************************
  // settings to the datapath
  // ****************************************
  // bit 10 is stored but unused; host keeps it zero
  always_comb begin
    cfg.gainEn = globalGainEnable;
    cfg.offsetEn = globalOffsetEnable;
    cfg.hpfEn = patCtrl[adc_proc_pkg::HPF_EN_BIT];
    cfg.roundEn = patCtrl[adc_proc_pkg::ROUND_BIT];
    // out-of-range k is not trapped: behaviour is left to the host
    cfg.corner = patCtrl[adc_proc_pkg::CORNER_LSB +: adc_proc_pkg::CORNER_W];
    for (int i = 0; i < 4; i++) begin
      cfg.go[i].gain = goWord[i][adc_proc_pkg::GAIN_MSB:adc_proc_pkg::GAIN_LSB];
      cfg.go[i].offset = goWord[i][adc_proc_pkg::OFFSET_MSB:adc_proc_pkg::OFFSET_LSB];
    end
  end

  sample_proc proc (
    .sys_clk(sys_clk),
    .reset(reset),
    .cfg(cfg),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inSample(sample),
    .outValid(procValid),
    .outReady(fifoReady),
    .outSample(procOut)
  );

  // ****************************************
  // test pattern substitution
  // ****************************************
  assign lane9Pattern = patCtrl[adc_proc_pkg::PAT9_LSB +: adc_proc_pkg::PAT_W];
  assign lane10Pattern = patCtrl[adc_proc_pkg::PAT10_LSB +: adc_proc_pkg::PAT_W];
  // lane n uses prbs bit 15-n; all gated by per-lane select
  assign prbsOn = perLanePatternSelect
                  && patCtrl[adc_proc_pkg::PRBS_LANE9_BIT - int'(procOut.conv)];
  assign push = procValid && fifoReady;

  // pattern codes pass as codes; the serializer owns their encoding
  always_comb begin
    fifoIn.lane = procOut.conv;
    fifoIn.prbs = prbsOn;
    fifoIn.pattern = 3'h0;
    if (perLanePatternSelect && procOut.conv == 2'h0) fifoIn.pattern = lane9Pattern;
    if (perLanePatternSelect && procOut.conv == 2'h1) fifoIn.pattern = lane10Pattern;
    fifoIn.data = prbsOn ? prbsState[13:0] : procOut.data;
  end

  // one shared prbs-15 source, stepped per prbs word so stalls do not skip values
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prbsState <= adc_proc_pkg::PRBS_SEED;
    end else if (push && prbsOn) begin
      prbsState <= {prbsState[13:0], prbsState[14] ^ prbsState[13]};
    end
  end

  sample_fifo #(
    .WIDTH($bits(adc_proc_pkg::lane_word_type)),
    .DEPTH(adc_proc_pkg::FIFO_DEPTH)
  ) fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .wrValid(procValid),
    .wrReady(fifoReady),
    .wrData(fifoIn),
    .rdValid(laneValid),
    .rdReady(laneReady),
    .rdData(laneWord),
    .level(fifoLevel)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_apb_unmapped:
    assert property (setupPhase && !mapped |=> pslverr && pready)
      else $error("unmapped address not refused");
  a_parity_map:
    assert property (psel && penable && pwrite && !pslverr && pstrb[1:0] == 2'b11
                     && regIdx == adc_proc_pkg::IDX_C12_ODD
                     |=> cfg.go[3] == {$past(pwdata[15:11]), $past(pwdata[9:0])})
      else $error("odd word of converter 12 misplaced");
  a_prbs_lane9:
    assert property (push && perLanePatternSelect && procOut.conv == 2'h0
                     && patCtrl[adc_proc_pkg::PRBS_LANE9_BIT]
                     |-> fifoIn.prbs && fifoIn.data == prbsState[13:0]
                     ##1 prbsState != $past(prbsState))
      else $error("lane 9 prbs not sent");
  a_pattern_gate:
    assert property (push && !perLanePatternSelect
                     |-> !fifoIn.prbs && fifoIn.pattern == 3'h0 && fifoIn.data == procOut.data)
      else $error("pattern active without per-lane select");
  a_reset_zero:
    assert property ($past(reset) |-> patCtrl == 16'h0000 && goWord[0] == 16'h0000
                     && goWord[3] == 16'h0000 && !globalGainEnable && !globalOffsetEnable
                     && !perLanePatternSelect)
      else $error("fields not zero after reset");
  c_trim_on: cover property (procValid && cfg.gainEn && cfg.offsetEn);
  c_fifo_full: cover property (procValid && !fifoReady);
  c_prbs_push: cover property (push && fifoIn.prbs);
  c_hpf_round: cover property (sampleValid && sampleReady && cfg.hpfEn && cfg.roundEn);
endmodule // adc9_12_digital_proc_config
`default_nettype wire

// ### apb_host.sv
// apb host model that programs the configuration registers
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  input wire logic sys_clk, // system clock
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [7:0] paddr, // byte address
  output logic [31:0] pwdata, // write data
  output logic [3:0] pstrb, // byte strobes
  input wire logic pready, // slave ready
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr // slave error
);
  // ****
  // idle bus from time zero
  // ****
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end
  // one transfer, entered just after an edge; request held until pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= 4'h3;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next setup never lands in the same time step
    @(posedge sys_clk);
  endtask
endmodule // apb_host
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the converter 9-12 configuration and sample path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic sampleValid, sampleReady, laneValid, laneReady;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [15:0] q;
  adc_proc_pkg::sample_type sample;
  adc_proc_pkg::lane_word_type laneWord;
  int err_total, tests_run, cycles, pushed, drained;
  adc9_12_digital_proc_config u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sample(sample), .laneValid(laneValid),
    .laneReady(laneReady), .laneWord(laneWord));
  apb_host u_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  // ****
  // clock and hang guard
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      $display("[ERR] %0t run hung", $time);
      wrap_up();
    end
  end
  // ****
  // shared tasks
  // ****
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x, input logic xe);
    u_host.xfer(1'b0, a, 16'h0000, q, e);
    chk(q, x);
    chk({15'h0000, e}, {15'h0000, xe});
  endtask
  // one sample in, one lane word out; header is {lane, prbs, pattern}
  task automatic send(input logic [1:0] c, input logic o, input logic [13:0] d,
                      input logic [5:0] hdr, input logic [13:0] x, input logic cd);
    int n;
    sample <= '{conv: c, odd: o, data: d};
    sampleValid <= 1'b1;
    do @(posedge sys_clk); while (sampleReady !== 1'b1);
    sampleValid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (laneValid !== 1'b1 && n < 50);
    // a word that never shows is a mismatch, not a silent pass
    if (laneValid !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t no lane word", $time);
    end
    chk({10'h000, laneWord.lane, laneWord.prbs, laneWord.pattern}, {10'h000, hdr});
    if (cd) chk({2'b00, laneWord.data}, {2'b00, x});
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    reset = 1'b1;
    sampleValid = 1'b0;
    sample = '0;
    laneReady = 1'b1;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) rd(8'hA8 + 8'(4 * i), 16'h0000, 1'b0);
    rd(8'h00, 16'h0000, 1'b1);
    wr(8'hB0, 16'h2BFF);
    rd(8'hB0, 16'h2BFF, 1'b0);
    send(2'd3, 1'b0, 14'd1000, 6'h30, 14'd1000, 1'b1);
    wr(8'h0C, 16'h0100);
    send(2'd3, 1'b0, 14'd1000, 6'h30, 14'd1001, 1'b1);
    wr(8'hAC, 16'h0002);
    send(2'd3, 1'b1, 14'd1000, 6'h30, 14'd998, 1'b1);
    wr(8'h0C, 16'h1000);
    send(2'd3, 1'b0, 14'd1000, 6'h30, 14'd1122, 1'b1);
    send(2'd3, 1'b1, 14'd1000, 6'h30, 14'd1000, 1'b1);
    wr(8'h0C, 16'h0000);
    send(2'd3, 1'b0, 14'd1000, 6'h30, 14'd1000, 1'b1);
    wr(8'hB4, 16'h9600);
    send(2'd0, 1'b0, 14'd1000, 6'h00, 14'd1000, 1'b1);
    wr(8'h10, 16'h0100);
    // shared prbs from an all-ones seed: words 3fff then 3ffe
    send(2'd0, 1'b0, 14'd1000, 6'h0B, 14'h3FFF, 1'b1);
    send(2'd3, 1'b0, 14'd1000, 6'h38, 14'h3FFE, 1'b1);
    send(2'd1, 1'b0, 14'd1000, 6'h10, 14'd1000, 1'b1);
    wr(8'h10, 16'h0000);
    wr(8'hB4, 16'h0005);
    send(2'd0, 1'b0, 14'd1000, 6'h00, 14'd1000, 1'b1);
    send(2'd0, 1'b0, 14'd1000, 6'h00, 14'd750, 1'b1);
    send(2'd0, 1'b0, 14'd1000, 6'h00, 14'd562, 1'b1);
    wr(8'hB4, 16'h0025);
    send(2'd1, 1'b0, 14'd1000, 6'h10, 14'd1000, 1'b1);
    send(2'd1, 1'b0, 14'd1000, 6'h10, 14'd750, 1'b1);
    send(2'd1, 1'b0, 14'd1000, 6'h10, 14'd563, 1'b1);
    wr(8'hB4, 16'h0000);
    send(2'd0, 1'b0, 14'd1000, 6'h00, 14'd1000, 1'b1);
    wr(8'hF8, 16'h0000);
    chk({15'h0000, e}, 16'h0001);
    // fill with the serializer stalled, then drain and count
    laneReady <= 1'b0;
    sampleValid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (sampleReady === 1'b1) pushed++;
    end while (sampleReady === 1'b1 && pushed < 40);
    sampleValid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'hF8, 16'h0320, 1'b0);
    laneReady <= 1'b1;
    repeat (60) begin
      @(posedge sys_clk);
      if (laneValid === 1'b1) drained++;
    end
    chk(16'(drained), 16'(pushed));
    // fifo words, its read register and the stage register
    chk(16'(pushed), 16'(adc_proc_pkg::FIFO_DEPTH + 2));
    rd(8'hF8, 16'h0000, 1'b0);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
